// file: mmie_pkg.sv
// Package: constants and carrier types of the MAC and management interrupt events
package mmie_pkg;
    localparam int unsigned MMIE_NCHAN = 8;
    localparam int unsigned MMIE_NSTAT = 36;
    localparam int unsigned MMIE_AW = 12;
    // Register byte offsets
    localparam logic [11:0] MMIE_TX_RAW = 12'h000;
    localparam logic [11:0] MMIE_TX_GATED = 12'h004;
    localparam logic [11:0] MMIE_TX_EN_SET = 12'h008;
    localparam logic [11:0] MMIE_TX_EN_CLR = 12'h00C;
    localparam logic [11:0] MMIE_RX_RAW = 12'h010;
    localparam logic [11:0] MMIE_RX_GATED = 12'h014;
    localparam logic [11:0] MMIE_RX_EN_SET = 12'h018;
    localparam logic [11:0] MMIE_RX_EN_CLR = 12'h01C;
    localparam logic [11:0] MMIE_MAC_RAW = 12'h020;
    localparam logic [11:0] MMIE_MAC_GATED = 12'h024;
    localparam logic [11:0] MMIE_MAC_EN_SET = 12'h028;
    localparam logic [11:0] MMIE_MAC_EN_CLR = 12'h02C;
    localparam logic [11:0] MMIE_LINK_RAW = 12'h030;
    localparam logic [11:0] MMIE_LINK_GATED = 12'h034;
    localparam logic [11:0] MMIE_LINK_EN = 12'h038;
    localparam logic [11:0] MMIE_ACC_RAW = 12'h040;
    localparam logic [11:0] MMIE_ACC_GATED = 12'h044;
    localparam logic [11:0] MMIE_ACC_EN_SET = 12'h048;
    localparam logic [11:0] MMIE_ACC_EN_CLR = 12'h04C;
    localparam logic [11:0] MMIE_GLOBAL_CTL = 12'h050;
    localparam logic [11:0] MMIE_DESC_ERR = 12'h054;
    // Arrays: selector in bits 11:8, word index in bits 7:2
    localparam logic [3:0] MMIE_TX_CP_PAGE = 4'h1;
    localparam logic [3:0] MMIE_RX_CP_PAGE = 4'h2;
    localparam logic [3:0] MMIE_STAT_PAGE = 4'h3;
    // Field positions
    localparam int unsigned MMIE_STAT_BIT = 0;
    localparam int unsigned MMIE_HOST_BIT = 1;
    localparam int unsigned MMIE_GEN_BIT = 0;
    // Reset values
    localparam logic [31:0] MMIE_PTR_RST = 32'h0000_0000;
    localparam logic [7:0] MMIE_EN_RST = 8'h00;

    // Completion pointer write from the DMA engine
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [31:0] addr;
    } mmie_cpl_t;

    // Descriptor faults, one-cycle pulses
    typedef struct packed {
        logic bad_sop;
        logic sop_not_owned;
        logic null_next_mid;
        logic null_buf_ptr;
        logic zero_buf_len;
        logic pkt_len_err;
    } mmie_tx_fault_t;

    typedef struct packed {
        logic not_owned;
        logic null_buf_ptr;
    } mmie_rx_fault_t;
endpackage

// file: mmie_events.sv
// Interrupt event logic: completion, statistics, descriptor error, management
//
// Register access over APB and the placing of the registers are this design's own decisions.
module mmie_events
    import mmie_pkg::*;
#(
    parameter int unsigned NSTAT = MMIE_NSTAT,
    parameter int unsigned CW = 32
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [MMIE_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // DMA engine events
    input wire mmie_cpl_t tx_cpl,
    input wire mmie_cpl_t rx_cpl,
    input wire mmie_tx_fault_t tx_fault,
    input wire mmie_rx_fault_t rx_fault,
    input wire logic [NSTAT-1:0] stat_inc,
    // Management engine state
    input wire logic [1:0] phy_link_up,
    input wire logic [1:0] phy_access_busy,
    // Interrupt outputs
    output logic [7:0] tx_done_irq,
    output logic [7:0] rx_done_irq,
    output logic counter_overflow_irq,
    output logic descriptor_error_irq,
    output logic link_change_irq,
    output logic access_done_irq,
    output logic combined_irq
);
    logic [7:0] tx_raw, rx_raw, tx_en, rx_en;
    logic [31:0] tx_cp [MMIE_NCHAN];
    logic [31:0] rx_cp [MMIE_NCHAN];
    logic [CW-1:0] stat_cnt [NSTAT];
    logic stat_raw, host_raw, stat_en, host_en;
    logic [7:0] host_cause;
    logic [1:0] link_raw, link_en, link_prev;
    logic [1:0] acc_raw, acc_en, acc_prev;
    logic global_en;
    logic [31:0] next_rdata;
    logic next_slverr;

    // Bus decode; one wait state so read data leaves a flip-flop
    logic acc_ph, wr_fire;
    logic [3:0] page;
    logic [5:0] idx;
    assign acc_ph = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite;
    assign page = paddr[11:8];
    assign idx = paddr[7:2];

    logic wr_tx_cp, wr_rx_cp, wr_stat;
    assign wr_tx_cp = wr_fire && page == MMIE_TX_CP_PAGE && idx < 6'd8;
    assign wr_rx_cp = wr_fire && page == MMIE_RX_CP_PAGE && idx < 6'd8;
    assign wr_stat = wr_fire && page == MMIE_STAT_PAGE
        && 32'(idx) < NSTAT;

    function automatic logic wr_reg(input logic [11:0] off);
        wr_reg = wr_fire && paddr == off;
    endfunction

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= acc_ph;
            prdata <= acc_ph ? next_rdata : 32'h0000_0000;
            pslverr <= acc_ph & next_slverr;
        end
    end

    // Per-channel completion pointers and pending bits
    genvar g;
    generate
        for (g = 0; g < MMIE_NCHAN; g++)
        begin : g_chan
            logic tx_dev, rx_dev, tx_ack, rx_ack;
            assign tx_dev = tx_cpl.valid && tx_cpl.chan == 3'(g);
            assign rx_dev = rx_cpl.valid && rx_cpl.chan == 3'(g);
            assign tx_ack = wr_tx_cp && idx == 6'(g);
            assign rx_ack = wr_rx_cp && idx == 6'(g);

            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    tx_cp[g] <= MMIE_PTR_RST;
                    tx_raw[g] <= 1'b0;
                end
                else if (tx_dev)
                begin
                    // Only the engine updates the pointer; set beats ack
                    tx_cp[g] <= tx_cpl.addr;
                    tx_raw[g] <= 1'b1;
                end
                else if (tx_ack && pwdata == tx_cp[g])
                    tx_raw[g] <= 1'b0;
            end

            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    rx_cp[g] <= MMIE_PTR_RST;
                    rx_raw[g] <= 1'b0;
                end
                else if (rx_dev)
                begin
                    rx_cp[g] <= rx_cpl.addr;
                    rx_raw[g] <= 1'b1;
                end
                else if (rx_ack && pwdata == rx_cp[g])
                    rx_raw[g] <= 1'b0;
            end
        end
    endgenerate

    // Statistics counters: increment and host decrement may coincide
    generate
        for (g = 0; g < NSTAT; g++)
        begin : g_stat
            logic dec;
            assign dec = wr_stat && 32'(idx) == g;
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                    stat_cnt[g] <= '0;
                else
                    stat_cnt[g] <= stat_cnt[g] + CW'(stat_inc[g])
                        - (dec ? pwdata[CW-1:0] : '0);
            end
        end
    endgenerate

    always_comb
    begin
        stat_raw = 1'b0;
        for (int i = 0; i < NSTAT; i++)
            stat_raw = stat_raw | stat_cnt[i][CW-1];
    end

    // Descriptor error: no software clear exists at all
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            host_raw <= 1'b0;
            host_cause <= 8'h00;
        end
        else if (|tx_fault || |rx_fault)
        begin
            host_raw <= 1'b1;
            host_cause <= host_cause | {tx_fault, rx_fault};
        end
    end

    // Enable registers, set/clear pairs
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_en <= MMIE_EN_RST;
            rx_en <= MMIE_EN_RST;
        end
        else
        begin
            if (wr_reg(MMIE_TX_EN_SET))
                tx_en <= tx_en | pwdata[7:0];
            else if (wr_reg(MMIE_TX_EN_CLR))
                tx_en <= tx_en & ~pwdata[7:0];
            if (wr_reg(MMIE_RX_EN_SET))
                rx_en <= rx_en | pwdata[7:0];
            else if (wr_reg(MMIE_RX_EN_CLR))
                rx_en <= rx_en & ~pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stat_en <= 1'b0;
            host_en <= 1'b0;
        end
        else if (wr_reg(MMIE_MAC_EN_SET))
        begin
            stat_en <= stat_en | pwdata[MMIE_STAT_BIT];
            host_en <= host_en | pwdata[MMIE_HOST_BIT];
        end
        else if (wr_reg(MMIE_MAC_EN_CLR))
        begin
            stat_en <= stat_en & ~pwdata[MMIE_STAT_BIT];
            host_en <= host_en & ~pwdata[MMIE_HOST_BIT];
        end
    end

    // Link change per selector; event wins over write-one clear
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            link_prev <= 2'b00;
            link_raw <= 2'b00;
            link_en <= 2'b00;
        end
        else
        begin
            link_prev <= phy_link_up;
            if (wr_reg(MMIE_LINK_EN))
                link_en <= pwdata[1:0];
            link_raw <= (link_raw & ~(wr_reg(MMIE_LINK_GATED)
                ? pwdata[1:0] & link_en : 2'b00))
                | ((link_prev ^ phy_link_up) & link_en);
        end
    end

    // Access done on falling trigger bit
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            acc_prev <= 2'b00;
            acc_raw <= 2'b00;
            acc_en <= 2'b00;
        end
        else
        begin
            acc_prev <= phy_access_busy;
            if (wr_reg(MMIE_ACC_EN_SET))
                acc_en <= acc_en | pwdata[1:0];
            else if (wr_reg(MMIE_ACC_EN_CLR))
                acc_en <= acc_en & ~pwdata[1:0];
            acc_raw <= (acc_raw & ~(wr_reg(MMIE_ACC_GATED)
                ? pwdata[1:0] & acc_en : 2'b00))
                | (acc_prev & ~phy_access_busy);
        end
    end

    // Global enable; pacing is not modelled
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            global_en <= 1'b0;
        else if (wr_reg(MMIE_GLOBAL_CTL))
            global_en <= pwdata[MMIE_GEN_BIT];
    end

    // Registered gated outputs, one cycle behind the raw bits
    logic any_gated;
    assign any_gated = |(tx_raw & tx_en) | |(rx_raw & rx_en)
        | (stat_raw & stat_en) | (host_raw & host_en)
        | |(link_raw & link_en) | |(acc_raw & acc_en);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_done_irq <= 8'h00;
            rx_done_irq <= 8'h00;
            counter_overflow_irq <= 1'b0;
            descriptor_error_irq <= 1'b0;
            link_change_irq <= 1'b0;
            access_done_irq <= 1'b0;
            combined_irq <= 1'b0;
        end
        else
        begin
            tx_done_irq <= tx_raw & tx_en;
            rx_done_irq <= rx_raw & rx_en;
            counter_overflow_irq <= stat_raw & stat_en;
            descriptor_error_irq <= host_raw & host_en;
            link_change_irq <= |(link_raw & link_en);
            access_done_irq <= |(acc_raw & acc_en);
            // Off while disabled, so re-enable gives a fresh edge
            combined_irq <= global_en & any_gated;
        end
    end

    // Read mux
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (page == MMIE_TX_CP_PAGE && idx < 6'd8)
            next_rdata = tx_cp[idx[2:0]];
        else if (page == MMIE_RX_CP_PAGE && idx < 6'd8)
            next_rdata = rx_cp[idx[2:0]];
        else if (page == MMIE_STAT_PAGE && 32'(idx) < NSTAT)
            next_rdata = 32'(stat_cnt[idx]);
        else
        begin
            case (paddr)
                MMIE_TX_RAW: next_rdata = {24'h0, tx_raw};
                MMIE_TX_GATED: next_rdata = {24'h0, tx_raw & tx_en};
                MMIE_TX_EN_SET, MMIE_TX_EN_CLR:
                    next_rdata = {24'h0, tx_en};
                MMIE_RX_RAW: next_rdata = {24'h0, rx_raw};
                MMIE_RX_GATED: next_rdata = {24'h0, rx_raw & rx_en};
                MMIE_RX_EN_SET, MMIE_RX_EN_CLR:
                    next_rdata = {24'h0, rx_en};
                MMIE_MAC_RAW: next_rdata = {30'h0, host_raw, stat_raw};
                MMIE_MAC_GATED: next_rdata = {30'h0, host_raw & host_en,
                    stat_raw & stat_en};
                MMIE_MAC_EN_SET, MMIE_MAC_EN_CLR:
                    next_rdata = {30'h0, host_en, stat_en};
                MMIE_LINK_RAW: next_rdata = {30'h0, link_raw};
                MMIE_LINK_GATED: next_rdata = {30'h0, link_raw & link_en};
                MMIE_LINK_EN: next_rdata = {30'h0, link_en};
                MMIE_ACC_RAW: next_rdata = {30'h0, acc_raw};
                MMIE_ACC_GATED: next_rdata = {30'h0, acc_raw & acc_en};
                MMIE_ACC_EN_SET, MMIE_ACC_EN_CLR:
                    next_rdata = {30'h0, acc_en};
                MMIE_GLOBAL_CTL: next_rdata = {31'h0, global_en};
                MMIE_DESC_ERR: next_rdata = {24'h0, host_cause};
                default: next_slverr = 1'b1;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence reenable_s;
        !global_en ##1 global_en;
    endsequence

    sequence host_ack_s(logic [2:0] ch);
        wr_tx_cp && idx[2:0] == ch && !tx_cpl.valid;
    endsequence

    tx_cpl_set_a: assert property (tx_cpl.valid |=>
        tx_raw[$past(tx_cpl.chan)] && tx_cp[$past(tx_cpl.chan)]
        == $past(tx_cpl.addr))
        else $error("tx completion did not raise pending");
    tx_ack_eq_a: assert property (host_ack_s(3'd5)
        and pwdata == tx_cp[5] |=> !tx_raw[5] ##1 !tx_done_irq[5])
        else $error("tx ack with equal pointer did not clear");
    tx_ack_ne_a: assert property ((host_ack_s(3'd5)
        and pwdata != tx_cp[5] and tx_raw[5]) |=> tx_raw[5])
        else $error("tx ack with unequal pointer cleared");
    cp_hold_a: assert property (wr_tx_cp && !tx_cpl.valid |=>
        tx_cp[$past(idx[2:0])] == $past(tx_cp[idx[2:0]]))
        else $error("host write altered completion pointer");
    rx_cpl_set_a: assert property (rx_cpl.valid |=>
        rx_raw[$past(rx_cpl.chan)] ##1 (rx_done_irq[$past(rx_cpl.chan, 2)]
        == rx_en[$past(rx_cpl.chan, 2)]))
        else $error("rx completion did not raise pending");
    stat_msb_a: assert property (stat_en && stat_raw
        |=> counter_overflow_irq)
        else $error("stats interrupt missing with counter msb set");
    host_sticky_a: assert property (host_raw |=> host_raw)
        else $error("descriptor error cleared without reset");
    host_fault_a: assert property (|tx_fault || |rx_fault
        |=> host_raw ##1 (descriptor_error_irq == $past(host_en)))
        else $error("descriptor fault not flagged");
    link_w1c_a: assert property (wr_fire && paddr == MMIE_LINK_GATED
        && pwdata[1] && link_en[1] && !(link_prev[1] ^ phy_link_up[1])
        |=> !link_raw[1])
        else $error("link gated write one did not clear");
    acc_fall_a: assert property (acc_prev[1] && !phy_access_busy[1]
        |=> acc_raw[1])
        else $error("access done not recorded on trigger fall");
    reassert_a: assert property (reenable_s ##0 $past(any_gated)
        && any_gated |-> ##1 combined_irq && !$past(combined_irq, 1))
        else $error("global re-enable did not give fresh edge");
endmodule

// file: mmie_host_model.sv
// Host requester: turns bench requests into APB transfers
module mmie_host_model
    import mmie_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Bench request
    input wire logic req,
    input wire logic req_wr,
    input wire logic [MMIE_AW-1:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_done,
    output logic [31:0] req_rdata,
    output logic req_err,
    // APB requester
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [MMIE_AW-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge sys_clk)
    begin
        req_done <= 1'b0;
        if (sys_rst)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
        // Done blocks a restart while the bench drops its request
        else if (!psel && req && !req_done)
        begin
            psel <= 1'b1;
            pwrite <= req_wr;
            paddr <= req_addr;
            pwdata <= req_wdata;
        end
        else if (psel && !penable)
            penable <= 1'b1;
        else if (psel && pready)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            req_done <= 1'b1;
            req_rdata <= prdata;
            req_err <= pslverr;
            // Released lines show a changed value, not the last one
            paddr <= ~paddr;
            pwdata <= ~pwdata;
        end
    end
endmodule

// file: mmie_events_tb_top.sv
// Self-checking bench for the interrupt event block
module mmie_events_tb_top
    import mmie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned NS = 36;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req = 1'b0;
    logic req_wr = 1'b0;
    logic [11:0] req_addr = 12'h000;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic req_done, req_err, psel, penable, pwrite, pready, pslverr;
    logic [31:0] req_rdata, prdata, pwdata;
    logic [11:0] paddr;
    mmie_cpl_t tx_cpl = '0;
    mmie_cpl_t rx_cpl = '0;
    mmie_tx_fault_t tx_fault = '0;
    mmie_rx_fault_t rx_fault = '0;
    logic [NS-1:0] stat_inc = '0;
    logic [1:0] phy_link_up = 2'h0;
    logic [1:0] phy_access_busy = 2'h0;
    logic [7:0] tx_done_irq, rx_done_irq;
    logic counter_overflow_irq, descriptor_error_irq;
    logic link_change_irq, access_done_irq, combined_irq;
    int n_errors = 0;
    int checks_done = 0;

    always #5 sys_clk = ~sys_clk;

    mmie_host_model i_mmie_host_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .req(req), .req_wr(req_wr), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata),
        .req_err(req_err), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    mmie_events #(.NSTAT(NS), .CW(32)) i_mmie_events (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_cpl(tx_cpl), .rx_cpl(rx_cpl),
        .tx_fault(tx_fault), .rx_fault(rx_fault), .stat_inc(stat_inc),
        .phy_link_up(phy_link_up), .phy_access_busy(phy_access_busy),
        .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
        .counter_overflow_irq(counter_overflow_irq),
        .descriptor_error_irq(descriptor_error_irq),
        .link_change_irq(link_change_irq), .access_done_irq(access_done_irq),
        .combined_irq(combined_irq));

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        // Start on an edge so the request never moves between edges
        @(posedge sys_clk);
        req <= 1'b1;
        req_wr <= wr;
        req_addr <= a;
        req_wdata <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (req_done !== 1'b1 && n < 40);
        q = req_rdata;
        e = req_err;
        req <= 1'b0;
        if (n >= 40)
        begin
            n_errors++;
            results;
        end
        // One edge between requests so the strobe is never rewritten
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input string nm, input logic [11:0] a,
        input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, x, q);
    endtask

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        settle;
    endtask

    task automatic t_reset;
        logic [31:0] q;
        logic e;
        chk("irqs", {11'h000, tx_done_irq, rx_done_irq, counter_overflow_irq,
            descriptor_error_irq, link_change_irq, access_done_irq,
            combined_irq}, 32'h0);
        rd("tx_en", MMIE_TX_EN_SET, 32'h0);
        rd("tx_cp1", 12'h104, MMIE_PTR_RST);
        rd("stat0", 12'h300, 32'h0);
        for (int i = 0; i < NS; i++)
            wr(12'h300 + 12'(4 * i), 32'h0);
        rd("stat_last", 12'h38C, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0, q, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
        $display("test reset done");
    endtask

    task automatic cpl_pulse(input logic rx, input logic [31:0] a);
        @(posedge sys_clk);
        if (rx)
            rx_cpl <= '{1'h1, 3'h5, a};
        else
            tx_cpl <= '{1'h1, 3'h5, a};
        @(posedge sys_clk);
        rx_cpl.valid <= 1'b0;
        tx_cpl.valid <= 1'b0;
        settle;
    endtask

    // Channel 5 of one direction: raise, stale ack, good ack, masked
    task automatic t_cpl(input logic rx);
        logic [11:0] b;
        logic [11:0] cp;
        b = rx ? 12'h010 : 12'h000;
        cp = {rx ? MMIE_RX_CP_PAGE : MMIE_TX_CP_PAGE, 8'h14};
        wr(b + 12'h00C, 32'h0000_00FF);
        wr(b + 12'h008, 32'h0000_0020);
        rd("en", b + 12'h008, 32'h20);
        cpl_pulse(rx, 32'h0000_A5A0);
        chk("irq", {24'h0, rx ? rx_done_irq : tx_done_irq}, 32'h20);
        rd("raw", b, 32'h20);
        rd("gated", b + 12'h004, 32'h20);
        rd("cp", cp, 32'h0000_A5A0);
        cpl_pulse(rx, 32'h0000_A5B0);
        wr(cp, 32'h0000_A5A0);
        settle;
        chk("stale", {24'h0, rx ? rx_done_irq : tx_done_irq}, 32'h20);
        rd("cp_kept", cp, 32'h0000_A5B0);
        wr(cp, 32'h0000_A5B0);
        settle;
        chk("acked", {24'h0, rx ? rx_done_irq : tx_done_irq}, 32'h0);
        rd("raw_clr", b, 32'h0);
        wr(b + 12'h00C, 32'h0000_0020);
        cpl_pulse(rx, 32'h0000_0000);
        rd("raw_m", b, 32'h20);
        rd("gated_m", b + 12'h004, 32'h0);
        chk("irq_m", {24'h0, rx ? rx_done_irq : tx_done_irq}, 32'h0);
        wr(cp, 32'h0000_0000);
        $display("test completion %0d done", rx);
    endtask

    task automatic t_stat;
        wr(MMIE_MAC_EN_SET, 32'h1);
        wr(12'h38C, 32'h8000_0000);
        settle;
        chk("stat_irq", {31'h0, counter_overflow_irq}, 32'h1);
        rd("mac_raw", MMIE_MAC_RAW, 32'h1);
        rd("cnt", 12'h38C, 32'h8000_0000);
        @(posedge sys_clk);
        stat_inc[NS-1] <= 1'b1;
        @(posedge sys_clk);
        stat_inc[NS-1] <= 1'b0;
        rd("cnt_inc", 12'h38C, 32'h8000_0001);
        wr(12'h38C, 32'h8000_0001);
        settle;
        chk("stat_off", {31'h0, counter_overflow_irq}, 32'h0);
        rd("cnt_zero", 12'h38C, 32'h0);
        wr(MMIE_MAC_EN_CLR, 32'h1);
        $display("test statistics done");
    endtask

    task automatic t_link;
        wr(MMIE_LINK_EN, 32'h3);
        @(posedge sys_clk);
        phy_link_up <= 2'h2;
        settle;
        chk("link_irq", {31'h0, link_change_irq}, 32'h1);
        rd("link_raw", MMIE_LINK_RAW, 32'h2);
        rd("link_gated", MMIE_LINK_GATED, 32'h2);
        wr(MMIE_LINK_GATED, 32'h2);
        settle;
        chk("link_clr", {31'h0, link_change_irq}, 32'h0);
        wr(MMIE_LINK_EN, 32'h0);
        phy_link_up <= 2'h3;
        settle;
        rd("link_off", MMIE_LINK_GATED, 32'h0);
        $display("test link done");
    endtask

    task automatic t_acc;
        wr(MMIE_ACC_EN_SET, 32'h1);
        phy_access_busy <= 2'h3;
        @(posedge sys_clk);
        phy_access_busy <= 2'h0;
        settle;
        chk("acc_irq", {31'h0, access_done_irq}, 32'h1);
        rd("acc_raw", MMIE_ACC_RAW, 32'h3);
        rd("acc_gated", MMIE_ACC_GATED, 32'h1);
        wr(MMIE_GLOBAL_CTL, 32'h1);
        settle;
        chk("comb_on", {31'h0, combined_irq}, 32'h1);
        wr(MMIE_GLOBAL_CTL, 32'h0);
        settle;
        chk("comb_off", {31'h0, combined_irq}, 32'h0);
        wr(MMIE_GLOBAL_CTL, 32'h1);
        settle;
        chk("comb_again", {31'h0, combined_irq}, 32'h1);
        wr(MMIE_ACC_GATED, 32'h1);
        settle;
        chk("acc_clr", {30'h0, access_done_irq, combined_irq}, 32'h0);
        $display("test access done");
    endtask

    task automatic t_desc;
        wr(MMIE_MAC_EN_SET, 32'h2);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            {tx_fault, rx_fault} <= 8'h01 << i;
            @(posedge sys_clk);
            {tx_fault, rx_fault} <= 8'h00;
            settle;
            chk("err_irq", {31'h0, descriptor_error_irq}, 32'h1);
            rd("cause", MMIE_DESC_ERR, (32'h2 << i) - 32'h1);
        end
        wr(MMIE_MAC_EN_CLR, 32'h2);
        settle;
        chk("err_mask", {31'h0, descriptor_error_irq}, 32'h0);
        rd("err_raw", MMIE_MAC_RAW, 32'h2);
        rd("err_gated", MMIE_MAC_GATED, 32'h0);
        do_reset;
        rd("err_rst", MMIE_MAC_RAW, 32'h0);
        rd("cause_rst", MMIE_DESC_ERR, 32'h0);
        $display("test descriptor error done");
    endtask

    initial
    begin
        do_reset;
        t_reset;
        t_cpl(1'b0);
        t_cpl(1'b1);
        t_stat;
        t_link;
        t_acc;
        t_desc;
        results;
    end
endmodule
